// file: rlc_codec.sv
// Rate 2/3 (1,7) run-length-limited encoder and decoder
`timescale 1ns/100ps

module rlc_codec
  import rlc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clocks and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic nrz_clk,
  // Write side pins from the controller
  input  wire logic wr_nrz_clk_pin,
  input  wire logic wr_nrz_data_pin,
  // Write configuration
  input  wire logic encoder_run,
  input  wire logic odd_frame_select_n,
  // Channel code out
  output logic      code_out,
  output logic      code_out_valid,
  // Synchroniser pins
  input  wire logic phase_lock_pin,
  input  wire logic sync_code_pin,
  input  wire logic sync_code_clk_pin,
  // Decode configuration and status
  input  wire logic error_fill_select,
  input  wire logic decode_error_clear,
  output logic      decode_error_flag,
  output logic      decoder_locked,
  // Read data to the controller
  input  wire logic read_gate_pin,
  output logic      rd_data,
  output logic      rd_data_valid
);

  // ----------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------
  function automatic logic [CODE_W-1:0] enc_word(
    input logic [1:0] cur,
    input logic [1:0] nxt,
    input logic       r0
  );
    logic [CODE_W-1:0] c;
    c = 3'h0;
    case (cur)
      2'h0: c = !nxt[1] ? 3'h1 : (r0 ? 3'h2 : 3'h0);
      2'h1: begin
        if (nxt[1]) c = 3'h0;
        else if (!r0) c = 3'h1;
        else c = nxt[0] ? 3'h0 : 3'h2;
      end
      2'h2: c = nxt[1] ? 3'h2 : 3'h5;
      default: c = (nxt == 2'h0) ? 3'h2 : 3'h4;
    endcase
    return c;
  endfunction : enc_word

  function automatic logic [WORD_W-1:0] dec_word(
    input logic [WIN_W-1:0] w
  );
    logic [1:0] z;
    z = 2'h0;
    case (w[4:2])
      3'h0: z = w[6] ? 2'h0 : 2'h1;
      3'h1: z = (w[6:5] == 2'h0) ? 2'h1 : 2'h0;
      3'h2: begin
        if (w[5]) z = (w[1:0] == 2'h0) ? 2'h1 : 2'h0;
        else z = (w[1:0] == 2'h0) ? 2'h3 : 2'h2;
      end
      3'h4: z = 2'h3;
      3'h5: z = 2'h2;
      default: z = 2'h0;
    endcase
    return z;
  endfunction : dec_word

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [PIN_W-1:0] pin_s1, pin_s2;
  logic             wclk_q, cclk_q;
  logic             wr_rise, code_rise;

  // Two flops on every pin that is not on mclk
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
    end else begin
      pin_s1 <= {sync_code_clk_pin, sync_code_pin, phase_lock_pin,
                 wr_nrz_data_pin, wr_nrz_clk_pin};
      pin_s2 <= pin_s1;
    end
  end

  // Edge history of the synchronised clocks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wclk_q <= PIN_RST[P_WCLK];
      cclk_q <= PIN_RST[P_CCLK];
    end else begin
      wclk_q <= pin_s2[P_WCLK];
      cclk_q <= pin_s2[P_CCLK];
    end
  end

  assign wr_rise   = pin_s2[P_WCLK] & ~wclk_q & encoder_run;
  assign code_rise = pin_s2[P_CCLK] & ~cclk_q;

  // ----------------------------------------------------------
  // Write framing
  // ----------------------------------------------------------
  logic       run_q;
  logic       half_reg, half_full_reg;
  logic [1:0] pend_reg;
  logic       pend_valid_reg;
  logic       enc_load;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
    end else begin
      run_q <= encoder_run;
    end
  end

  // Pair serial write bits; even framing pads a leading zero bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      half_reg      <= EVEN_PAD_BIT;
      half_full_reg <= 1'b0;
    end else if (encoder_run && !run_q) begin
      half_reg      <= EVEN_PAD_BIT;
      half_full_reg <= odd_frame_select_n;
    end else if (wr_rise) begin
      half_reg      <= pin_s2[P_WDAT];
      half_full_reg <= ~half_full_reg;
    end
  end

  // One pending pair; a new pair wins over its consumption
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg       <= IDLE_WORD;
      pend_valid_reg <= 1'b0;
    end else if (!encoder_run) begin
      pend_valid_reg <= 1'b0;
    end else if (wr_rise && half_full_reg) begin
      pend_reg       <= {half_reg, pin_s2[P_WDAT]};
      pend_valid_reg <= 1'b1;
    end else if (enc_load) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------
  logic [1:0]        phase_reg;
  logic [1:0]        nxt_reg;
  logic [1:0]        new_nxt;
  logic              r0_reg;
  logic [CODE_W-1:0] enc_code;
  logic [1:0]        code_sr;

  assign enc_load = encoder_run & (phase_reg == ENC_LAST_PH);
  assign new_nxt  = pend_valid_reg ? pend_reg : IDLE_WORD;
  assign enc_code = enc_word(nxt_reg, new_nxt, r0_reg);

  // Bit phase within the code word
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 2'h0;
    end else if (!encoder_run || enc_load) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Lookahead pair and last code bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nxt_reg <= IDLE_WORD;
      r0_reg  <= R0_RESET;
    end else if (!encoder_run) begin
      nxt_reg <= IDLE_WORD;
      r0_reg  <= R0_RESET;
    end else if (enc_load) begin
      nxt_reg <= new_nxt;
      r0_reg  <= enc_code[0];
    end
  end

  // Serialise the code word, first bit first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      code_out       <= 1'b0;
      code_out_valid <= 1'b0;
      code_sr        <= 2'h0;
    end else if (enc_load) begin
      code_out       <= enc_code[2];
      code_out_valid <= 1'b1;
      code_sr        <= enc_code[1:0];
    end else begin
      code_out       <= encoder_run & code_sr[1];
      code_out_valid <= encoder_run & code_out_valid;
      code_sr        <= {code_sr[0], 1'b0};
    end
  end

  // ----------------------------------------------------------
  // Sync hunt and decode window
  // ----------------------------------------------------------
  rlc_dec_state_t    state_reg;
  logic [SYNC_W-2:0] hist_reg;
  logic [1:0]        cnt_reg;
  logic              cbit;
  logic              hunt_hit;
  logic [WIN_W-1:0]  dec_win;
  logic              dec_fire;
  logic              adj;

  assign cbit     = pin_s2[P_CDAT];
  assign hunt_hit = code_rise && ({hist_reg, cbit} == SYNC_PATTERN);
  assign dec_win  = {hist_reg[WIN_W-2:0], cbit};
  assign dec_fire = (state_reg == DEC_RUN) && code_rise &&
                    (cnt_reg == DEC_FIRE_CNT);
  assign adj      = |(dec_win[WIN_W-1:1] & dec_win[WIN_W-2:0]);

  // Code bit history
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hist_reg <= '0;
    end else if (code_rise) begin
      hist_reg <= {hist_reg[SYNC_W-3:0], cbit};
    end
  end

  // Detector state: idle without phase lock, hunt, then run
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= DEC_IDLE;
    end else begin
      case (state_reg)
        DEC_IDLE: if (pin_s2[P_LOCK]) state_reg <= DEC_HUNT;
        DEC_HUNT: begin
          if (!pin_s2[P_LOCK]) state_reg <= DEC_IDLE;
          else if (hunt_hit) state_reg <= DEC_RUN;
        end
        DEC_RUN: if (!pin_s2[P_LOCK]) state_reg <= DEC_IDLE;
        default: state_reg <= DEC_IDLE;
      endcase
    end
  end

  // Bit position from the sync word boundary
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 2'h0;
    end else if (state_reg != DEC_RUN) begin
      cnt_reg <= 2'h0;
    end else if (code_rise) begin
      cnt_reg <= (cnt_reg == DEC_LAST_CNT) ? 2'h0 : cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      decoder_locked <= 1'b0;
    end else begin
      decoder_locked <= (state_reg == DEC_RUN) && pin_s2[P_LOCK];
    end
  end

  // ----------------------------------------------------------
  // Decoded word, error fill and error flag
  // ----------------------------------------------------------
  logic [1:0] dec_data_reg;
  logic       dec_valid_reg;
  logic       fifo_in_ready;

  // Held until the FIFO takes it; a newer word overwrites
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dec_data_reg  <= IDLE_WORD;
      dec_valid_reg <= 1'b0;
    end else if (dec_fire) begin
      dec_valid_reg <= 1'b1;
      if (adj) begin
        dec_data_reg <= error_fill_select ? FILL_ONES : FILL_ZEROS;
      end else begin
        dec_data_reg <= dec_word(dec_win);
      end
    end else if (fifo_in_ready) begin
      dec_valid_reg <= 1'b0;
    end
  end

  // Sticky error; a new error wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      decode_error_flag <= 1'b0;
    end else if (dec_fire && adj) begin
      decode_error_flag <= 1'b1;
    end else if (decode_error_clear) begin
      decode_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // FIFO and read serialiser on the NRZ clock
  // ----------------------------------------------------------
  logic       fifo_out_valid;
  logic [1:0] fifo_out_data;
  logic       fifo_out_ready;
  logic       gate_s1, gate_s2;
  logic       bit_sel_reg;
  logic       ser_bit_reg, ser_valid_reg;

  rlc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .wr_clk    (mclk),
    .wr_rst_b  (rst_b),
    .in_valid  (dec_valid_reg),
    .in_data   (dec_data_reg),
    .in_ready  (fifo_in_ready),
    .rd_clk    (nrz_clk),
    .rd_rst_b  (rst_b),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  // Word leaves with its second bit
  assign fifo_out_ready = gate_s2 & fifo_out_valid & bit_sel_reg;

  always_ff @(posedge nrz_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
    end else begin
      gate_s1 <= read_gate_pin;
      gate_s2 <= gate_s1;
    end
  end

  // High bit first, then low bit
  always_ff @(posedge nrz_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_sel_reg   <= 1'b0;
      ser_bit_reg   <= 1'b0;
      ser_valid_reg <= 1'b0;
    end else if (gate_s2 && fifo_out_valid) begin
      bit_sel_reg   <= ~bit_sel_reg;
      ser_bit_reg   <= bit_sel_reg ? fifo_out_data[0] : fifo_out_data[1];
      ser_valid_reg <= 1'b1;
    end else begin
      ser_valid_reg <= 1'b0;
      ser_bit_reg   <= 1'b0;
    end
  end

  // Falling-edge launch puts each bit mid-way between rising edges
  always_ff @(negedge nrz_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data       <= 1'b0;
      rd_data_valid <= 1'b0;
    end else begin
      rd_data       <= ser_bit_reg;
      rd_data_valid <= ser_valid_reg;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  sequence code_101_s;
    code_out ##1 !code_out ##1 code_out;
  endsequence

  sequence run_three_s;
    encoder_run [*3];
  endsequence

  enc_rate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (enc_load ##1 run_three_s) |-> enc_load)
    else $error("code word spacing is not three clocks");

  enc_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (enc_load && nxt_reg == 2'h2 && !new_nxt[1]) |=> code_101_s)
    else $error("pair 10 before 0x did not encode as 101");

  sync_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == DEC_HUNT && $past(state_reg) != DEC_RUN ##1 state_reg == DEC_RUN)
    |-> $past(hunt_hit))
    else $error("decoder started without sync pattern");

  lock_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !pin_s2[P_LOCK] |=> state_reg == DEC_IDLE ##1 !decoder_locked)
    else $error("detector active without phase lock");

  err_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (dec_fire && adj) |=> decode_error_flag)
    else $error("adjacent ones did not set error flag");

  err_fill_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (dec_fire && adj) |=>
      dec_data_reg == ($past(error_fill_select) ? FILL_ONES : FILL_ZEROS))
    else $error("illegal window not filled");

  err_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (decode_error_flag && !decode_error_clear) |=> decode_error_flag)
    else $error("error flag dropped without clear");

  legal_win_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (dec_fire && !adj && !decode_error_flag) |=> !decode_error_flag)
    else $error("legal window raised an error");

  zero_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (dec_fire && dec_win == 7'h00) |=> dec_data_reg == 2'h1 && dec_valid_reg)
    else $error("zero run did not decode as 01");

  dec_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (dec_fire && dec_win == 7'h54) |=> dec_data_reg == 2'h2)
    else $error("window 10 101 00 did not decode as 10");

endmodule : rlc_codec

// file: rlc_codec_tb_top.sv
// Self-checking bench for the run-length-limited codec
`timescale 1ns/100ps

module rlc_codec_tb_top;
  import rlc_pkg::*;
  localparam int DEPTH_TB = 4;
  logic       mclk, nrz_clk, rst_b, wclk, wdat, gate, rgate;
  logic       encoder_run, odd_frame_select_n, code_out, code_out_valid;
  logic       phase_lock_pin, sync_code_pin, sync_code_clk_pin;
  logic       error_fill_select, decode_error_clear, decode_error_flag;
  logic       decoder_locked, rd_data, rd_data_valid;
  logic       cq[$];
  logic       ecap[$];
  logic [1:0] exp_q[$];
  int         n_errors, check_count, seed, kb;

  rlc_codec #(.DEPTH(DEPTH_TB)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .nrz_clk(nrz_clk),
    .wr_nrz_clk_pin(wclk), .wr_nrz_data_pin(wdat),
    .encoder_run(encoder_run), .odd_frame_select_n(odd_frame_select_n),
    .code_out(code_out), .code_out_valid(code_out_valid),
    .phase_lock_pin(phase_lock_pin), .sync_code_pin(sync_code_pin),
    .sync_code_clk_pin(sync_code_clk_pin), .error_fill_select(error_fill_select),
    .decode_error_clear(decode_error_clear), .decode_error_flag(decode_error_flag),
    .decoder_locked(decoder_locked), .read_gate_pin(rgate),
    .rd_data(rd_data), .rd_data_valid(rd_data_valid));

  rlc_ctrl_model u_ctrl (
    .mclk(mclk), .nrz_clk(nrz_clk), .wr_nrz_clk_pin(wclk), .wr_nrz_data_pin(wdat),
    .rd_data(rd_data), .rd_data_valid(rd_data_valid), .gate(gate),
    .read_gate_pin(rgate));

  // Clocks, the link clock with its own phase
  always #4 mclk = ~mclk;
  initial begin
    nrz_clk = 1'b0;
    #3.3;
    forever #7.5 nrz_clk = ~nrz_clk;
  end

  // Code stream capture while the encoder runs
  always @(posedge mclk) begin
    if (code_out_valid === 1'b1) ecap.push_back(code_out);
  end

  // Expected NRZ word of a seven-bit window
  function automatic logic [1:0] dec_exp(input logic [6:0] w, input logic fill);
    logic [1:0] p;
    p = w[6:5];
    if (|(w & (w >> 1))) return fill ? FILL_ONES : FILL_ZEROS;
    case (w[4:2])
      3'h0: return p[1] ? 2'h0 : 2'h1;
      3'h1: return (|p) ? 2'h0 : 2'h1;
      3'h2: return {~p[0], w[1:0] == 2'h0};
      3'h4: return 2'h3;
      default: return 2'h2;
    endcase
  endfunction : dec_exp

  // Window of word k, stream led by two zero bits
  function automatic logic [6:0] win(input logic q[$], input int k);
    logic [6:0] w;
    for (int j = 0; j < 7; j++) w[6-j] = q[3*k+j];
    return w;
  endfunction : win

  // Random legal code word keeping ones apart across the boundary
  function automatic logic [2:0] rnd_word(input logic last);
    logic [2:0] c;
    c = 3'($unsigned($random(seed)) % 5);
    if (c > 3'h2) c = c + 3'h1;
    if (last && c[2]) c = 3'h2;
    return c;
  endfunction : rnd_word

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t word got %b exp %b", $time, got, exp);
    end
  endtask : check_word

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Synchroniser side: one code bit per six channel clocks
  task automatic send_code(input logic [2:0] cw);
    for (int j = 2; j >= 0; j--) begin
      @(posedge mclk);
      sync_code_clk_pin <= 1'b0;
      sync_code_pin <= cw[j];
      cq.push_back(cw[j]);
      repeat (3) @(posedge mclk);
      sync_code_clk_pin <= 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask : send_code

  task automatic wait_rx(input int n);
    for (int i = 0; i < 5000 && u_ctrl.rx_q.size() < n; i++) @(posedge mclk);
    check_bit(u_ctrl.rx_q.size() >= n, 1'b1);
  endtask : wait_rx

  // Encodes random nonzero pairs, then decodes the code stream back
  task automatic enc_run(input logic frame_n);
    logic [1:0] pr[$];
    logic [1:0] p;
    logic [6:0] w;
    int         m;
    ecap = '{1'b0, 1'b0};
    odd_frame_select_n <= frame_n;
    @(posedge mclk);
    encoder_run <= 1'b1;
    if (frame_n) begin
      pr.push_back(2'h1);
      u_ctrl.send_bit(1'b1);  // Lone first bit pairs with the pad
    end
    repeat (8) begin
      p = 2'($unsigned($random(seed)) % 3 + 1);
      pr.push_back(p);
      u_ctrl.send_bit(p[1]);
      u_ctrl.send_bit(p[0]);
    end
    repeat (40) @(posedge mclk);
    encoder_run <= 1'b0;
    repeat (4) @(posedge mclk);
    m = 0;
    for (int k = 0; k < (ecap.size() - 2) / 3 - 1; k++) begin
      w = win(ecap, k);
      check_bit(|(w & (w >> 1)), 1'b0);
      // Word 0 has no real history before it, so it carries no pair
      if (k > 0 && dec_exp(w, 1'b0) != 2'h0 && m < pr.size()) begin
        check_word(dec_exp(w, 1'b0), pr[m]);
        m++;
      end
    end
    check_bit(m == pr.size(), 1'b1);
  endtask : enc_run

  // Main sequence
  initial begin
    seed = 9;
    n_errors = 0;
    check_count = 0;
    mclk = 1'b0;
    rst_b = 1'b0;
    encoder_run = 1'b0;
    odd_frame_select_n = 1'b0;
    phase_lock_pin = 1'b0;
    sync_code_pin = 1'b0;
    sync_code_clk_pin = 1'b1;
    error_fill_select = 1'b1;
    decode_error_clear = 1'b0;
    gate = 1'b1;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    check_bit(code_out_valid, 1'b0);
    check_bit(decoder_locked, 1'b0);
    check_bit(decode_error_flag, 1'b0);
    enc_run(1'b0);
    enc_run(1'b1);
    repeat (3) send_code(3'h1);
    repeat (6) @(posedge mclk);
    check_bit(decoder_locked, 1'b0);
    phase_lock_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    cq = '{1'b0, 1'b0};
    send_code(3'h0);
    repeat (3) send_code(3'h1);
    repeat (6) @(posedge mclk);
    check_bit(decoder_locked, 1'b1);
    repeat (3) send_code(3'h0);
    send_code(3'h2);
    send_code(3'h5);
    send_code(3'h0);
    repeat (20) send_code(rnd_word(cq[cq.size()-1]));
    check_bit(decode_error_flag, 1'b0);
    send_code(3'h3);
    repeat (2) send_code(3'h0);
    check_bit(decode_error_flag, 1'b1);
    repeat (20) @(posedge mclk);
    check_bit(decode_error_flag, 1'b1);
    decode_error_clear <= 1'b1;
    @(posedge mclk);
    decode_error_clear <= 1'b0;
    repeat (2) @(posedge mclk);
    check_bit(decode_error_flag, 1'b0);
    kb = (cq.size() - 2) / 3;
    wait_rx(kb - 4);
    // Gate closed: FIFO fills and refuses, then drains
    gate <= 1'b0;
    error_fill_select <= 1'b0;
    repeat (10) @(posedge mclk);
    send_code(3'h4);
    send_code(3'h3);
    repeat (8) send_code(3'h0);
    for (int k = 3; k < (cq.size() - 2) / 3 - 1; k++)
      exp_q.push_back(dec_exp(win(cq, k), k < kb));
    gate <= 1'b1;
    wait_rx(kb);
    for (int i = 0; i < kb; i++) begin
      check_word(u_ctrl.rx_q[i], exp_q[i]);
    end
    // Output stage, FIFO and holding register keep DEPTH_TB + 2 words
    repeat (300) @(posedge mclk);
    check_bit(u_ctrl.rx_q.size() == kb + DEPTH_TB - 2, 1'b1);
    check_word(u_ctrl.rx_q[kb + DEPTH_TB - 3], exp_q[exp_q.size() - 1]);
    check_bit(decode_error_flag, 1'b1);
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    check_bit(decoder_locked, 1'b0);
    check_bit(decode_error_flag, 1'b0);
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule : rlc_codec_tb_top

// file: rlc_ctrl_model.sv
// Disk controller model: drives the write NRZ pins and collects read NRZ words
`timescale 1ns/100ps

module rlc_ctrl_model (
  // Clocks
  input  wire logic mclk,
  input  wire logic nrz_clk,
  // Write pins
  output logic      wr_nrz_clk_pin,
  output logic      wr_nrz_data_pin,
  // Read pins
  input  wire logic rd_data,
  input  wire logic rd_data_valid,
  input  wire logic gate,
  output logic      read_gate_pin
);
  logic [1:0] rx_q[$];
  logic       hi_bit;
  logic       half;

  initial begin
    wr_nrz_clk_pin = 1'b1;
    wr_nrz_data_pin = 1'b0;
    hi_bit = 1'b0;
    half = 1'b0;
  end

  assign read_gate_pin = gate;

  // One bit per write clock, data settled before the rising edge
  task automatic send_bit(input logic b);
    @(posedge mclk);
    wr_nrz_clk_pin <= 1'b0;
    wr_nrz_data_pin <= b;
    repeat (3) @(posedge mclk);
    wr_nrz_clk_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    wr_nrz_data_pin <= ~b;  // Hold time over, line no longer shows the bit
  endtask : send_bit

  // Read bits taken on the rising NRZ clock, high bit first
  always @(posedge nrz_clk) begin
    if (rd_data_valid === 1'b1) begin
      if (half) rx_q.push_back({hi_bit, rd_data});
      hi_bit = rd_data;
      half = ~half;
    end
  end
endmodule : rlc_ctrl_model

// file: rlc_fifo.sv
// Codec constants and the dual-clock word FIFO of the read path
`timescale 1ns/100ps

// ------------------------------------------------------------
// Shared constants
// ------------------------------------------------------------
package rlc_pkg;
  localparam int         WORD_W       = 2;
  localparam int         CODE_W       = 3;
  localparam int         WIN_W        = 7;
  localparam int         SYNC_W       = 9;
  localparam int         FIFO_DEPTH   = 32;
  localparam logic [8:0] SYNC_PATTERN = 9'h049;  // 001001001
  localparam logic [1:0] FILL_ZEROS   = 2'h0;
  localparam logic [1:0] FILL_ONES    = 2'h3;
  localparam logic [1:0] IDLE_WORD    = 2'h0;
  localparam logic [1:0] ENC_LAST_PH  = 2'h2;   // three bit times per word
  localparam logic [1:0] DEC_FIRE_CNT = 2'h1;   // second bit of next word
  localparam logic [1:0] DEC_LAST_CNT = 2'h2;
  localparam logic       R0_RESET     = 1'b0;
  localparam logic       EVEN_PAD_BIT = 1'b0;
  // Pin synchroniser lanes
  localparam int         PIN_W        = 5;
  localparam int         P_WCLK       = 0;
  localparam int         P_WDAT       = 1;
  localparam int         P_LOCK       = 2;
  localparam int         P_CDAT       = 3;
  localparam int         P_CCLK       = 4;
  // Clock lanes rest high so reset release shows no false rising edge
  localparam logic [PIN_W-1:0] PIN_RST = 5'h11;
  typedef enum logic [1:0] {
    DEC_IDLE = 2'b00,
    DEC_HUNT = 2'b01,
    DEC_RUN  = 2'b10
  } rlc_dec_state_t;
endpackage : rlc_pkg

// ------------------------------------------------------------
// Dual-clock FIFO, gray pointers, registered read data
// ------------------------------------------------------------
module rlc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  // Write side
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Read side
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_b,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_reg, rbin_reg, wgray, rgray;
  logic [AW:0]      rg_s1, rg_s2, wg_s1, wg_s2;
  logic             wr_go, rd_go;

  assign wgray    = wbin_reg ^ (wbin_reg >> 1);
  assign rgray    = rbin_reg ^ (rbin_reg >> 1);
  // Full when write pointer is one lap ahead of read pointer
  assign in_ready = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign wr_go    = in_valid & in_ready;
  assign rd_go    = (rgray != wg_s2) & (~out_valid | out_ready);

  // Write pointer and storage
  always_ff @(posedge wr_clk or negedge wr_rst_b) begin
    if (!wr_rst_b) begin
      wbin_reg <= '0;
    end else if (wr_go) begin
      wbin_reg <= wbin_reg + 1'b1;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_go) begin
      mem[wbin_reg[AW-1:0]] <= in_data;
    end
  end

  // Read pointer into the write domain
  always_ff @(posedge wr_clk or negedge wr_rst_b) begin
    if (!wr_rst_b) begin
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
    end
  end

  // Write pointer into the read domain
  always_ff @(posedge rd_clk or negedge rd_rst_b) begin
    if (!rd_rst_b) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
    end
  end

  // Registered output stage
  always_ff @(posedge rd_clk or negedge rd_rst_b) begin
    if (!rd_rst_b) begin
      rbin_reg  <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (rd_go) begin
      rbin_reg  <= rbin_reg + 1'b1;
      out_valid <= 1'b1;
      out_data  <= mem[rbin_reg[AW-1:0]];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : rlc_fifo
